// ### shared/dmc_pkg.sv
// constants for the decimation mode control block
// Summary of operation
// - two mode pins pick one of four output word rates; 00 default
// - output words sit left-justified on the 16-bit bus
// - mode 00 decimates by 6, one word per six converter clocks
// - mode 01 decimates by 3, one word every three clocks
// - decimate-by-3 drops to 14 effective bits but drives all 16
// - decimate-by-3 group delay is 13 word-ready cycles
// - mode 10 decimates by 12, one word every twelve clocks
// - mode 11 bypasses filtering, one 12-bit word per clock
// - power-down input low stops the device; high resumes it
// - word-ready low marks each new output word; in bypass it stays low
// - words are two's complement, clipped to 7fff (7ff0 in bypass) and 8000
// - overrange flag changes only when a new word is marked or power-down clears it
package dmc_pkg;
   localparam logic [1:0] MODE_DEC6 = 2'h0;
   localparam logic [1:0] MODE_DEC3 = 2'h1;
   localparam logic [1:0] MODE_DEC12 = 2'h2;
   localparam logic [1:0] MODE_BYPASS = 2'h3;
   localparam logic [3:0] RATIO_DEC6 = 4'h6;
   localparam logic [3:0] RATIO_DEC3 = 4'h3;
   localparam logic [3:0] RATIO_DEC12 = 4'hc;
   localparam logic [3:0] RATIO_BYPASS = 4'h1;
   // reciprocal gains, 1.16 fixed point
   localparam logic [16:0] RECIP_DEC6 = 17'h02aab;
   localparam logic [16:0] RECIP_DEC3 = 17'h05555;
   localparam logic [16:0] RECIP_DEC12 = 17'h01555;
   localparam logic [16:0] RECIP_BYPASS = 17'h10000;
   localparam logic [4:0] GD_DEC6 = 5'h1e;
   localparam logic [4:0] GD_DEC3 = 5'h0d;
   localparam logic [4:0] GD_DEC12 = 5'h1e;
   localparam logic [4:0] GD_BYPASS = 5'h00;
   localparam int GD_MAX = 30;
   localparam logic [5:0] SETTLE_DEC6 = 6'h37;
   localparam logic [5:0] SETTLE_DEC3 = 6'h19;
   localparam logic [5:0] SETTLE_DEC12 = 6'h37;
   localparam logic [5:0] SETTLE_BYPASS = 6'h00;
   localparam logic [15:0] POS_FS = 16'h7fff;
   localparam logic [15:0] NEG_FS = 16'h8000;
   localparam logic [15:0] MASK_BYPASS = 16'hfff0;
   localparam logic [15:0] MASK_FULL = 16'hffff;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_DATA = 4'h8;
   localparam logic [3:0] REG_SETTLE = 4'hc;
   localparam int CTRL_SOFT_PD = 0;
   localparam int STAT_MODE_LO = 0;
   localparam int STAT_SETTLED = 2;
   localparam int STAT_ACTIVE = 3;
   localparam int STAT_OVR = 4;
   localparam int DATA_OVR = 16;
   localparam logic CTRL_RESET = 1'b0;
endpackage

// ### hw/dmc_top.sv
// decimation mode control with avalon-mm status and control registers
`timescale 1ns/10ps
module dmc_top
   import dmc_pkg::*;
#(
   parameter int SAMPLE_W = 18
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [1:0] mode_sel,
   input wire logic power_down_n,
   input wire logic signed [SAMPLE_W-1:0] mod_sample,
   output logic [15:0] data_out,
   output logic overrange_flag,
   output logic word_ready_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   localparam int SUM_W = SAMPLE_W + 4;
   localparam int PROD_W = SUM_W + 18;

   function automatic logic [3:0] ratio_of(input logic [1:0] m);
      unique case (m)
         MODE_DEC6: return RATIO_DEC6;
         MODE_DEC3: return RATIO_DEC3;
         MODE_DEC12: return RATIO_DEC12;
         MODE_BYPASS: return RATIO_BYPASS;
      endcase
   endfunction

   function automatic logic [16:0] recip_of(input logic [1:0] m);
      unique case (m)
         MODE_DEC6: return RECIP_DEC6;
         MODE_DEC3: return RECIP_DEC3;
         MODE_DEC12: return RECIP_DEC12;
         MODE_BYPASS: return RECIP_BYPASS;
      endcase
   endfunction

   function automatic logic [4:0] gd_of(input logic [1:0] m);
      unique case (m)
         MODE_DEC6: return GD_DEC6;
         MODE_DEC3: return GD_DEC3;
         MODE_DEC12: return GD_DEC12;
         MODE_BYPASS: return GD_BYPASS;
      endcase
   endfunction

   function automatic logic [5:0] settle_of(input logic [1:0] m);
      unique case (m)
         MODE_DEC6: return SETTLE_DEC6;
         MODE_DEC3: return SETTLE_DEC3;
         MODE_DEC12: return SETTLE_DEC12;
         MODE_BYPASS: return SETTLE_BYPASS;
      endcase
   endfunction

   // saturate to 16 bits; bit 16 marks overrange
   function automatic logic [16:0] clip_word(input logic signed [SUM_W-1:0] v);
      if (v > $signed({{(SUM_W-16){1'b0}}, POS_FS}))
         return {1'b1, POS_FS};
      else if (v < $signed({{(SUM_W-16){1'b1}}, NEG_FS}))
         return {1'b1, NEG_FS};
      else
         return {1'b0, v[15:0]};
   endfunction

   logic [1:0] mode_reg;
   logic soft_pd_reg;
   logic [3:0] cnt_reg;
   logic signed [SUM_W-1:0] acc_reg;
   logic [5:0] settle_reg;
   logic [16:0] dl_reg [GD_MAX];
   logic ack_reg;
   logic active;
   logic mode_change;
   logic run_ok;
   logic dec_done;
   logic signed [SUM_W-1:0] sum_now;
   logic signed [PROD_W-1:0] prod;
   logic [16:0] new_word;
   logic [16:0] out_word;
   logic [4:0] gd;

   assign active = power_down_n && !soft_pd_reg;
   assign mode_change = mode_sel != mode_reg;
   assign run_ok = active && !mode_change;
   assign dec_done = run_ok && (cnt_reg == ratio_of(mode_reg) - 4'h1);
   assign sum_now = acc_reg + SUM_W'(mod_sample);
   assign prod = sum_now * $signed({1'b0, recip_of(mode_reg)});
   assign gd = gd_of(mode_reg);

   // bypass keeps 12 bits; decimate-by-3 still drives all 16 bits
   always_comb begin
      new_word = clip_word(SUM_W'(prod >>> 16));
      if (mode_reg == MODE_BYPASS)
         new_word[15:0] = new_word[15:0] & MASK_BYPASS;
      else
         new_word[15:0] = new_word[15:0] & MASK_FULL;
      out_word = (gd == 5'h00) ? new_word : dl_reg[gd - 5'h01];
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         mode_reg <= MODE_DEC6;
      else
         mode_reg <= mode_sel;
   end

   // one boxcar sum per word; restart on any mode change
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_reg <= 4'h0;
         acc_reg <= '0;
      end else if (!run_ok || dec_done) begin
         cnt_reg <= 4'h0;
         acc_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + 4'h1;
         acc_reg <= sum_now;
      end
   end

   // words age through the line to give the mode's group delay
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < GD_MAX; i++)
            dl_reg[i] <= '0;
      end else if (dec_done) begin
         dl_reg[0] <= new_word;
         for (int i = 1; i < GD_MAX; i++)
            dl_reg[i] <= dl_reg[i-1];
      end
   end

   // in bypass the strobe stays low: one word every clock
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         data_out <= 16'h0000;
         overrange_flag <= 1'b0;
         word_ready_n <= 1'b1;
      end else if (!active) begin
         data_out <= 16'h0000;
         overrange_flag <= 1'b0;
         word_ready_n <= 1'b1;
      end else if (dec_done) begin
         data_out <= out_word[15:0];
         overrange_flag <= out_word[16];
         word_ready_n <= 1'b0;
      end else begin
         word_ready_n <= 1'b1;
      end
   end

   // counts words since the last disturbance, saturating
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         settle_reg <= 6'h00;
      else if (!run_ok)
         settle_reg <= 6'h00;
      else if (dec_done && settle_reg != 6'h3f)
         settle_reg <= settle_reg + 6'h01;
   end

   // avalon slave: one wait cycle, then the answer
   assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         ack_reg <= 1'b0;
      else
         ack_reg <= (avs_read || avs_write) && !ack_reg;
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         soft_pd_reg <= CTRL_RESET;
      else if (avs_write && ack_reg && avs_address == REG_CTRL &&
               avs_byteenable[0])
         soft_pd_reg <= avs_writedata[CTRL_SOFT_PD];
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !ack_reg) begin
         avs_readdata <= 32'h0000_0000;
         unique case (avs_address)
            REG_CTRL: avs_readdata[CTRL_SOFT_PD] <= soft_pd_reg;
            REG_STATUS: begin
               avs_readdata[STAT_MODE_LO +: 2] <= mode_reg;
               avs_readdata[STAT_SETTLED] <=
                  settle_reg >= settle_of(mode_reg);
               avs_readdata[STAT_ACTIVE] <= active;
               avs_readdata[STAT_OVR] <= overrange_flag;
            end
            REG_DATA: begin
               avs_readdata[15:0] <= data_out;
               avs_readdata[DATA_OVR] <= overrange_flag;
            end
            REG_SETTLE: avs_readdata[5:0] <= settle_reg;
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // helper: cycles between successive words during steady running
   logic [3:0] gap_reg;
   logic gap_ok_reg;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         gap_reg <= 4'h0;
         gap_ok_reg <= 1'b0;
      end else if (!run_ok) begin
         gap_ok_reg <= 1'b0;
      end else if (!word_ready_n) begin
         gap_reg <= 4'h1;
         gap_ok_reg <= 1'b1;
      end else if (gap_reg != 4'hf) begin
         gap_reg <= gap_reg + 4'h1;
      end
   end

   // helper: consecutive silent cycles while running, saturating
   logic [3:0] quiet_reg;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         quiet_reg <= 4'h0;
      else if (!(word_ready_n && run_ok))
         quiet_reg <= 4'h0;
      else if (quiet_reg != 4'hf)
         quiet_reg <= quiet_reg + 4'h1;
   end

   dec6_rate_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (!word_ready_n && gap_ok_reg && mode_reg == MODE_DEC6) |->
      gap_reg == 4'h6)
      else $error("decimate-by-6 word spacing wrong");
   dec3_rate_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (!word_ready_n && gap_ok_reg && mode_reg == MODE_DEC3) |->
      gap_reg == 4'h3)
      else $error("decimate-by-3 word spacing wrong");
   dec12_rate_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (!word_ready_n && gap_ok_reg && mode_reg == MODE_DEC12) |->
      gap_reg == 4'hc)
      else $error("decimate-by-12 word spacing wrong");
   mode_rate_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (word_ready_n && run_ok && quiet_reg >= 4'hb) |->
      mode_reg == MODE_DEC12)
      else $error("word-ready silent too long for mode");
   bypass_word_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (run_ok && mode_reg == MODE_BYPASS) [*2] |->
      !word_ready_n && data_out[3:0] == 4'h0)
      else $error("bypass word missing or low bits set");
   group_delay_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (!word_ready_n && gap_ok_reg && mode_reg == MODE_DEC3 &&
       settle_reg >= 6'h0e) |->
      {overrange_flag, data_out} == $past(new_word, 40))
      else $error("decimate-by-3 group delay not 13 words");
   clip_value_a: assert property (@(posedge mclk) disable iff (!reset_n)
      overrange_flag |-> (data_out == POS_FS || data_out == NEG_FS))
      else $error("overrange word not clipped to full scale");
   ovr_edge_a: assert property (@(posedge mclk) disable iff (!reset_n)
      ($changed(overrange_flag) && active) |-> !word_ready_n)
      else $error("overrange flag moved without a word");
   power_down_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !power_down_n |=> (word_ready_n && data_out == 16'h0000 &&
      cnt_reg == 4'h0))
      else $error("device kept running in power-down");
   word_pulse_a: assert property (@(posedge mclk) disable iff (!reset_n)
      $fell(word_ready_n) |-> $past(dec_done))
      else $error("word-ready fell without a new word");
endmodule // dmc_top

// ### bench/dmc_host.sv
// host model: counts words since the last disturbance
`timescale 1ns/10ps
module dmc_host
   import dmc_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic power_down_n,
   input wire logic [1:0] mode_sel,
   input wire logic word_ready_n,
   output logic [7:0] words_seen,
   output logic usable
);
   logic [1:0] mode_q;
   logic [5:0] need;
   // bypass has no settle figure, so its words are usable at once
   assign need = (mode_sel == MODE_DEC3) ? SETTLE_DEC3 :
      (mode_sel == MODE_BYPASS) ? SETTLE_BYPASS : SETTLE_DEC6;
   assign usable = ({2'h0, need} <= words_seen);
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         words_seen <= 8'h00;
         mode_q <= MODE_DEC6;
      end else if (!power_down_n || mode_sel != mode_q) begin
         words_seen <= 8'h00;
         mode_q <= mode_sel;
      end else if (!word_ready_n && words_seen != 8'hff) begin
         words_seen <= words_seen + 8'h01;
      end
   end
endmodule // dmc_host

// ### bench/tb_top.sv
// testbench for the decimation mode control block
`timescale 1ns/10ps
module tb_top
   import dmc_pkg::*;
;
   logic mclk, reset_n, power_down_n, avs_read, avs_write, ovr_q;
   logic overrange_flag, word_ready_n, avs_waitrequest, usable;
   logic [1:0] mode_sel;
   logic [3:0] avs_address, avs_byteenable;
   logic signed [17:0] mod_sample;
   logic [15:0] data_out;
   logic [31:0] avs_writedata, avs_readdata, d;
   int errors = 0, n_tests = 0, cyc = 0, p;
   int exp_p [4] = '{6, 3, 12, 1};
   dmc_top #(.SAMPLE_W(18)) dmc_top_inst (.mclk(mclk), .reset_n(reset_n),
      .mode_sel(mode_sel), .power_down_n(power_down_n),
      .mod_sample(mod_sample), .data_out(data_out),
      .overrange_flag(overrange_flag), .word_ready_n(word_ready_n),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(avs_byteenable),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   dmc_host dmc_host_inst (.mclk(mclk), .reset_n(reset_n),
      .power_down_n(power_down_n), .mode_sel(mode_sel),
      .word_ready_n(word_ready_n), .words_seen(), .usable(usable));
   always #4 mclk = ~mclk;
   task automatic print_verdict;
      if (errors == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic fail(input string m);
      errors++;
      $display("mismatch at %0t: %s", $time, m);
   endtask
   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) fail("register, flag or count");
   endtask
   // filter gains may round one code either way
   task automatic cmpw(input logic [15:0] got, input logic [15:0] exp);
      logic [15:0] df;
      df = got - exp;
      n_tests++;
      if ((^got === 1'bx) || (df > 16'h0001 && df < 16'hffff))
         fail("output word");
   endtask
   task automatic av(input logic w, input logic [3:0] a,
         input logic [3:0] be, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge mclk);
      avs_address <= a;
      avs_byteenable <= be;
      avs_writedata <= wd;
      avs_read <= !w;
      avs_write <= w;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      d = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n == 20) begin
         fail("bus hang");
         print_verdict;
      end
   endtask
   task automatic word_gap(output int g);
      int n;
      n = 0;
      while (word_ready_n !== 1'b0 && n < 40) begin
         @(posedge mclk);
         n++;
      end
      g = 0;
      do begin
         @(posedge mclk);
         g++;
      end while (word_ready_n !== 1'b0 && g < 40);
      if (n == 40 || g == 40) begin
         fail("word strobe missing");
         print_verdict;
      end
   endtask
   task automatic skip(input int k);
      repeat (k) word_gap(p);
   endtask
   task automatic quiet_check;
      int lows;
      lows = 0;
      repeat (3) @(posedge mclk);
      repeat (30) begin
         @(posedge mclk);
         if (word_ready_n !== 1'b1) lows++;
      end
      cmp32(lows, 32'h0);
   endtask
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors = errors + 1;
         print_verdict;
      end
   end
   // the flag may only move together with a word strobe
   always @(negedge mclk) begin
      if (reset_n && power_down_n && overrange_flag !== ovr_q &&
            word_ready_n !== 1'b0) fail("flag moved between words");
      ovr_q = overrange_flag;
   end
   initial begin
      mclk = 1'b0;
      reset_n = 1'b0;
      mode_sel = MODE_DEC6;
      power_down_n = 1'b1;
      mod_sample = 18'sh01235;
      avs_address = 4'h0;
      avs_byteenable = 4'h0;
      avs_writedata = 32'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      av(1'b0, REG_CTRL, 4'hf, 32'h0);
      cmp32(d, 32'h0);
      av(1'b0, 4'h2, 4'hf, 32'h0);
      cmp32(d, 32'h0);
      for (int m = 0; m < 4; m++) begin
         mode_sel <= m[1:0];
         repeat (3) word_gap(p);
         cmp32(p, exp_p[m]);
      end
      skip(40);
      cmpw(data_out, 16'h1230);
      mode_sel <= MODE_DEC3;
      skip(40);
      cmpw(data_out, 16'h1235);
      mod_sample <= -18'sh01235;
      skip(10);
      cmpw(data_out, 16'h1235);
      skip(6);
      cmpw(data_out, 16'hedcb);
      av(1'b0, REG_STATUS, 4'hf, 32'h0);
      cmp32(d[STAT_SETTLED], usable);
      cmp32(d[STAT_MODE_LO +: 2], MODE_DEC3);
      mode_sel <= MODE_DEC6;
      mod_sample <= 18'sd40000;
      skip(40);
      av(1'b0, REG_STATUS, 4'hf, 32'h0);
      cmp32(d[STAT_SETTLED], usable);
      cmpw(data_out, POS_FS);
      cmp32(overrange_flag, 1'b1);
      mod_sample <= -18'sd40000;
      skip(40);
      cmpw(data_out, NEG_FS);
      av(1'b0, REG_DATA, 4'hf, 32'h0);
      cmp32(d[DATA_OVR], 1'b1);
      mod_sample <= 18'sh01235;
      skip(40);
      cmp32(overrange_flag, 1'b0);
      cmpw(data_out, 16'h1235);
      power_down_n <= 1'b0;
      quiet_check;
      cmpw(data_out, 16'h0000);
      power_down_n <= 1'b1;
      skip(5);
      av(1'b0, REG_STATUS, 4'hf, 32'h0);
      cmp32(d[STAT_SETTLED], 1'b0);
      cmp32(d, 32'h8);
      av(1'b1, REG_CTRL, 4'h1, 32'h1);
      av(1'b1, REG_CTRL, 4'h0, 32'h0);
      av(1'b0, REG_CTRL, 4'hf, 32'h0);
      cmp32(d, 32'h1);
      av(1'b0, REG_STATUS, 4'hf, 32'h0);
      cmp32(d, 32'h0);
      av(1'b0, REG_SETTLE, 4'hf, 32'h0);
      cmp32(d, 32'h0);
      quiet_check;
      av(1'b1, REG_CTRL, 4'h1, 32'h0);
      skip(3);
      cmp32(p, 32'h6);
      print_verdict;
   end
endmodule // tb_top
